// [logic/reset_source_logic.sv]
// Reset-source logic: software, watchdog and trap-conflict resets with cause flags
module reset_source_logic
  import rst_src_pkg::*;
(
  // Clock and power-on reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Processor core
  input wire logic reset_instr_i,
  input wire logic sleep_i,
  input wire logic idle_i,
  input wire logic [rst_src_pkg::PRIO_W-1:0] trap_active_prio_i,
  // Watchdog timer
  input wire logic watchdog_timeout_i,
  // Trap logic
  input wire logic trap_req_i,
  input wire logic [rst_src_pkg::PRIO_W-1:0] trap_req_prio_i,
  input wire logic addr_err_trap_i,
  input wire logic osc_fail_trap_i,
  // Software access to the cause flags
  input wire logic cause_wr_i,
  input wire logic [rst_src_pkg::CAUSE_W-1:0] cause_wdata_i,
  // Outputs
  output logic chip_wide_reset_o,
  output logic vector_fetch_o,
  output logic wake_o,
  output logic keep_clock_o,
  output logic [rst_src_pkg::CAUSE_W-1:0] reset_cause_register_o
);
  import rst_src_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  logic rst_s1_r;
  logic rst_s2_r;
  wire logic rst_n;
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  assign rst_n = rst_s2_r;

  ////////////////////////////////////////////////////////////////////////////
  // Trap classification
  function automatic logic is_hard(input logic [PRIO_W-1:0] p);
    is_hard = (p >= HARD_PRIO_MIN) && (p <= HARD_PRIO_MAX);
  endfunction

  wire logic [PRIO_W-1:0] req_prio;
  wire logic req_valid;
  wire logic req_hard;
  wire logic active_busy;
  wire logic req_lower;
  wire logic trap_conflict;
  wire logic sleeping;
  wire logic wdog_reset;
  wire logic wdog_wake;
  wire logic hw_cause;
  wire logic sw_request;
  // Fixed-level traps override the generic request priority
  assign req_prio = addr_err_trap_i ? ADDR_ERR_PRIO :
                    osc_fail_trap_i ? OSC_FAIL_PRIO : trap_req_prio_i;
  assign req_valid = trap_req_i | addr_err_trap_i | osc_fail_trap_i;
  assign req_hard = is_hard(req_prio);
  // Level zero means no trap is in service, so nothing can conflict with it
  assign active_busy = (trap_active_prio_i != PRIO_NONE);
  assign req_lower = (req_prio < trap_active_prio_i);
  assign trap_conflict = req_valid && req_hard && active_busy && req_lower;
  assign sleeping = sleep_i | idle_i;
  // The time-out sets the reset line asynchronously; a glitch on it while the core
  // runs would reset the whole chip, so the watchdog must drive it cleanly
  assign wdog_reset = watchdog_timeout_i & ~sleeping;
  assign wdog_wake = watchdog_timeout_i & sleeping;
  // Hardware causes outrank the instruction when both land together
  assign hw_cause = wdog_reset | trap_conflict;
  assign sw_request = reset_instr_i & ~hw_cause;

  ////////////////////////////////////////////////////////////////////////////
  // Reset state machine
  rst_state_e state_r;
  rst_state_e state_nxt;
  always_comb
  begin
    state_nxt = ST_RUN;
    case (state_r)
      ST_RUN:
        if (hw_cause)
          state_nxt = ST_HW_RST;
        else if (sw_request)
          state_nxt = ST_SW_RST;
      // A hardware cause during a reset in progress restarts it, so its
      // flag is never set without the reset that it records
      ST_SW_RST:
        if (hw_cause)
          state_nxt = ST_HW_RST;
        else
          state_nxt = ST_RUN;
      ST_HW_RST:
        if (hw_cause)
          state_nxt = ST_HW_RST;
        else
          state_nxt = ST_RUN;
      default: state_nxt = ST_RUN;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      state_r <= ST_RUN;
    else
      state_r <= state_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next values of the output flops
  wire logic reset_line_nxt;
  wire logic fetch_nxt;
  wire logic keep_clk_nxt;
  assign reset_line_nxt = (state_nxt != ST_RUN);
  assign fetch_nxt = (state_r != ST_RUN) && (state_nxt == ST_RUN);
  // Clock selection is held, not reloaded, during these resets
  assign keep_clk_nxt = (state_nxt != ST_RUN);

  // The watchdog sets the line without waiting for a clock edge, which
  // would never come if the oscillator stalled
  logic reset_line_r;
  always_ff @(posedge clk_i or negedge rst_n or posedge wdog_reset)
  begin
    if (!rst_n)
      reset_line_r <= 1'b0;
    else if (wdog_reset)
      reset_line_r <= 1'b1;
    else
      reset_line_r <= reset_line_nxt;
  end

  logic fetch_r;
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      fetch_r <= 1'b0;
    else
      fetch_r <= fetch_nxt;
  end

  logic wake_r;
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      wake_r <= 1'b0;
    else
      wake_r <= wdog_wake;
  end

  logic keep_clk_r;
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      keep_clk_r <= 1'b0;
    else
      keep_clk_r <= keep_clk_nxt;
  end
  assign chip_wide_reset_o = reset_line_r;
  assign vector_fetch_o = fetch_r;
  assign wake_o = wake_r;
  assign keep_clock_o = keep_clk_r;

  ////////////////////////////////////////////////////////////////////////////
  // Cause flags: only power-on reset or a software write clears them, so they outlive the reset
  // that they record
  wire logic instr_set;
  wire logic [CAUSE_W-1:0] cause_base;
  wire logic [CAUSE_W-1:0] cause_nxt;
  logic [CAUSE_W-1:0] cause_set;
  logic [CAUSE_W-1:0] cause_r;
  assign instr_set = (state_r == ST_RUN) && sw_request;
  // A software write only moves the flags and never starts a reset
  assign cause_base = cause_wr_i ? (cause_wdata_i & CAUSE_MASK) : cause_r;
  // Set wins over a clear landing in the same cycle
  assign cause_nxt = cause_base | cause_set;

  always_comb
  begin
    cause_set = CAUSE_RESET;
    cause_set[INSTR_RST_BIT] = instr_set;
    cause_set[WDOG_TO_BIT] = wdog_reset;
    cause_set[TRAP_CONF_BIT] = trap_conflict;
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      cause_r <= CAUSE_RESET;
    else
      cause_r <= cause_nxt;
  end
  assign reset_cause_register_o = cause_r;
endmodule // reset_source_logic

// [logic/rst_src_pkg.sv]
// Constants and types for the reset-source logic
package rst_src_pkg;
  localparam int unsigned CAUSE_W = 16;
  localparam int unsigned PRIO_W = 4;
  localparam int unsigned INSTR_RST_BIT = 6;
  localparam int unsigned WDOG_TO_BIT = 4;
  localparam int unsigned TRAP_CONF_BIT = 15;
  localparam logic [CAUSE_W-1:0] CAUSE_RESET = 16'h0000;
  localparam logic [CAUSE_W-1:0] CAUSE_MASK = 16'h8050;
  localparam logic [PRIO_W-1:0] HARD_PRIO_MIN = 4'hd;
  localparam logic [PRIO_W-1:0] HARD_PRIO_MAX = 4'hf;
  localparam logic [PRIO_W-1:0] ADDR_ERR_PRIO = 4'hd;
  localparam logic [PRIO_W-1:0] OSC_FAIL_PRIO = 4'he;
  localparam logic [PRIO_W-1:0] PRIO_NONE = 4'h0;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_SW_RST = 2'b01,
    ST_HW_RST = 2'b10
  } rst_state_e;
endpackage : rst_src_pkg

// [tb/core_model.sv]
// Core-side model: power mode levels and watchdog time-out pulse
module core_model (
  input wire logic clk_i,
  input wire logic [1:0] mode_i,
  input wire logic kick_i,
  output logic [2:0] st_o = 3'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  // Rising-edge update, so the bench's falling-edge drive never races it
  always @(posedge clk_i) st_o <= {mode_i, kick_i};
endmodule // core_model

// [tb/reset_source_sva.sv]
// Port assertions for the reset-source logic
module reset_source_sva
  import rst_src_pkg::*;
(
  input wire logic clk_i, rst_n_i, reset_instr_i, sleep_i, idle_i, watchdog_timeout_i,
  input wire logic trap_req_i, addr_err_trap_i, osc_fail_trap_i, cause_wr_i, wake_o,
  input wire logic chip_wide_reset_o, vector_fetch_o, keep_clock_o,
  input wire logic [PRIO_W-1:0] trap_active_prio_i, trap_req_prio_i,
  input wire logic [CAUSE_W-1:0] cause_wdata_i, reset_cause_register_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Idle with no watchdog time-out or fixed-level trap; overlapping causes are left out on purpose
  wire r = !chip_wide_reset_o && !vector_fetch_o && !watchdog_timeout_i && !addr_err_trap_i
    && !osc_fail_trap_i;
  wire n = r && !reset_instr_i && !trap_req_i;
  wire [15:0] c = reset_cause_register_o;
  sw_seq_a: assert property (reset_instr_i && r && !trap_req_i |=>
    chip_wide_reset_o && keep_clock_o && c[6] ##1 !chip_wide_reset_o && vector_fetch_o)
    else $error("sw reset");
  wd_run_a: assert property (watchdog_timeout_i && !sleep_i && !idle_i |->
    chip_wide_reset_o ##1 c[4] && keep_clock_o) else $error("wdog reset");
  wd_wake_a: assert property ($rose(watchdog_timeout_i) && (sleep_i || idle_i) |->
    !chip_wide_reset_o ##1 wake_o && !chip_wide_reset_o) else $error("wdog wake");
  conflict_a: assert property (r && trap_req_i && trap_req_prio_i >= HARD_PRIO_MIN
    && trap_req_prio_i < trap_active_prio_i |=> chip_wide_reset_o && c[15]) else $error("trap");
  soft_trap_a: assert property (r && !reset_instr_i && trap_req_i
    && trap_req_prio_i < HARD_PRIO_MIN |=> !chip_wide_reset_o) else $error("soft trap");
  fixed_trap_a: assert property (!chip_wide_reset_o && !vector_fetch_o &&
    (addr_err_trap_i && trap_active_prio_i > ADDR_ERR_PRIO || osc_fail_trap_i
    && trap_active_prio_i > OSC_FAIL_PRIO) |=> chip_wide_reset_o && c[15]) else $error("fixed");
  cause_wr_a: assert property (n && cause_wr_i |=> !chip_wide_reset_o
    && c == ($past(cause_wdata_i) & CAUSE_MASK)) else $error("cause write");
  cause_hold_a: assert property (n && !cause_wr_i |=> $stable(c)) else $error("hold");
  cover property (vector_fetch_o);
  cover property (wake_o);
  cover property ($rose(c[15]));
endmodule // reset_source_sva

// [tb/testbench.sv]
// Self-checking bench for the reset-source logic
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import rst_src_pkg::*;
  logic clk_i = 0, rst_n_i = 0, reset_instr_i = 0, trap_req_i = 0, addr_err_trap_i = 0;
  logic osc_fail_trap_i = 0, cause_wr_i = 0, kick = 0, chip_wide_reset_o, vector_fetch_o;
  logic wake_o, keep_clock_o;
  wire sleep_i, idle_i, watchdog_timeout_i;
  logic [1:0] mode = 0;
  logic [3:0] trap_active_prio_i = 0, trap_req_prio_i = 0;
  logic [15:0] cause_wdata_i = 0, reset_cause_register_o, exp_q[$];
  logic [11:0] tv[6] = '{12'hfd1, 12'hfe1, 12'hec0, 12'he05, 12'hf09, 12'hd08};
  int n_errors = 0, check_count = 0, seed = 32'h4390;
  event go;
  always #20 clk_i = ~clk_i;
  core_model partner (.clk_i, .mode_i(mode), .kick_i(kick),
    .st_o({idle_i, sleep_i, watchdog_timeout_i}));
  reset_source_logic dut (.*);
  task automatic check(logic [15:0] s, e, string w);
    check_count++;
    if (s !== e) $display("mismatch %s expected %h seen %h", w, e, s);
    n_errors += int'(s !== e);
  endtask
  task automatic step(int k);
    repeat (k) @(negedge clk_i);
  endtask
  task automatic note(logic [15:0] e);
    exp_q.push_back(e);
    ->go;
  endtask
  always @go check(reset_cause_register_o, exp_q.pop_front(), "cause");
  task automatic wr(logic [15:0] d);
    {cause_wr_i, cause_wdata_i} = {1'b1, d};
    step(1);
    cause_wr_i = 0;
    step(1);
    check(chip_wide_reset_o, 0, "write reset");
  endtask
  task automatic settle;
    for (int k = 0; k < 20 && chip_wide_reset_o !== 1'b0; k++) step(1);
    step(1);
  endtask
  task automatic dog;
    kick = 1;
    step(1);
    kick = 0;
    check(chip_wide_reset_o, !mode, "wdog reset");
    step(1);
    check(wake_o, |mode, "wake");
    check(keep_clock_o, !mode, "wdog clock");
    settle;
  endtask
  initial
  begin
    step(6);
    rst_n_i = 1;
    step(3);
    reset_instr_i = 1;
    step(1);
    reset_instr_i = 0;
    check(chip_wide_reset_o & keep_clock_o, 1, "sw reset");
    step(1);
    check({chip_wide_reset_o, vector_fetch_o}, 1, "fetch");
    settle;
    note(16'h0040);
    for (int i = 0; i < 3; i++)
    begin
      wr(i == 0 ? 16'hffff : i == 1 ? 16'($random(seed)) : 16'h0);
      note(cause_wdata_i & CAUSE_MASK);
    end
    dog;
    note(16'h0010);
    for (int m = 1; m < 3; m++)
    begin
      mode = 2'(m);
      wr(0);
      dog;
      note(16'h0000);
    end
    mode = 0;
    foreach (tv[i])
    begin
      wr(0);
      {trap_active_prio_i, trap_req_prio_i, osc_fail_trap_i, addr_err_trap_i} = tv[i][11:2];
      trap_req_i = tv[i][3:2] == 2'h0;
      step(1);
      {trap_req_i, osc_fail_trap_i, addr_err_trap_i} = 3'h0;
      check(chip_wide_reset_o, tv[i][0], "trap reset");
      settle;
      note({tv[i][0], 15'h0});
    end
    wr(16'hffff);
    rst_n_i = 0;
    step(2);
    rst_n_i = 1;
    step(3);
    note(CAUSE_RESET);
    complete_run;
  end
  initial
  begin
    #20000;
    n_errors++;
    complete_run;
  end
  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
endmodule // testbench
bind reset_source_logic reset_source_sva sva (.*);
